// File: core/boot_strap_cfg.svh
/*
 * boot_strap_cfg.svh: offsets, field positions, reset values and counts of the
 * boot strap capture block.
 * Assumes inclusion by bare name from files that use the macros.
 */
`ifndef BOOT_STRAP_CFG_SVH
`define BOOT_STRAP_CFG_SVH

// slow reference edges between reset release and override capture
`define BSC_SLOW_EDGES 3'h4

// register byte offsets
`define BSC_ADDR_STATUS 8'h00
`define BSC_ADDR_OVERRIDE 8'h04
`define BSC_ADDR_CTRL 8'h08

// status field positions
`define BSC_ST_SEL_LSB 0
`define BSC_ST_LOWBATT 2
`define BSC_ST_FREQ_LSB 3
`define BSC_ST_DONE 8

// control field positions and reset values
`define BSC_CTRL_HANDOVER 0
`define BSC_CTRL_RESET 1'h1

// captured values after reset
`define BSC_SEL_RESET 2'h0
`define BSC_OVR_RESET 24'h000000
`define BSC_FREQ_RESET 2'h0

`endif

// File: core/boot_strap_pkg.sv
/*
 * boot_strap_pkg: types of the boot strap capture block.
 * Assumes boot_strap_cfg.svh for numeric constants.
 */
package boot_strap_pkg;

    // capture sequence, one-hot
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_COUNT = 3'b010,
        ST_DONE = 3'b100
    } cap_state_t;

    // decoded boot mode; code 01 has no documented meaning
    typedef enum logic [1:0] {
        BOOT_INTERNAL = 2'h0,
        BOOT_RESERVED = 2'h1,
        BOOT_FUSE_ONLY = 2'h2,
        BOOT_USB_DL = 2'h3
    } boot_mode_t;

    // all state of the capture block
    typedef struct packed {
        cap_state_t state;
        logic slow_prev;
        logic [2:0] edge_cnt;
        logic [1:0] boot_sel;
        logic [23:0] override;
        logic lowbatt;
        logic [1:0] freq;
        logic done;
        logic handover;
        logic ack;
        logic [31:0] rdata;
    } cap_regs_t;

    // state of the two-flop synchroniser
    typedef struct packed {
        logic [63:0] s1;
        logic [63:0] s2;
    } sync_regs_t;

endpackage

// File: core/pin_sync.sv
/*
 * pin_sync: two-flop synchroniser for a group of pin levels.
 * Assumes pins are quasi-static levels; no bus coherence is promised.
 */
`timescale 1ns/1ps
module pin_sync
    import boot_strap_pkg::*;
#(
    parameter int WIDTH = 31
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    // struct holds at most 64 bits per stage, so wider groups are refused
    if (WIDTH < 1 || WIDTH > 64) begin : g_width_bad
        $error("pin_sync: WIDTH out of range");
    end

    sync_regs_t st_r;
    sync_regs_t st_nxt;

    // first stage feeds only the second stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = 64'h0;
        st_nxt.s1[WIDTH-1:0] = pin_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.s2[WIDTH-1:0];

endmodule

// File: core/boot_strap_capture.sv
/*
 * boot_strap_capture: latches boot straps around power-on reset release and
 * shows them over a classic Wishbone slave.
 * Assumes a 100 MHz clk_i, a 32.768 kHz slow reference far below it, and that
 * the memory interface and audio port obey the output enables given back here.
 */
// Operation
// - sample both boot-select straps when power-on reset releases; they set boot mode.
// - boot-select 00 internal, 10 fuses only, 11 USB download.
// - capture override straps exactly four slow reference cycles after reset release.
// - override straps are three 8-bit groups, 24 bits in all.
// - low-battery indication at power-up captures two-bit frequency strap for core frequency.
// - override straps share memory interface pins; those pins stay released until capture.
// - frequency bit 0 from audio frame sync pin, bit 1 from audio bit clock.
`timescale 1ns/1ps
`include "boot_strap_cfg.svh"
module boot_strap_capture
    import boot_strap_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // power-on reset pin and slow reference
    input wire logic por_n_i,
    input wire logic slow_reference_clock_i,
    // strap pins
    input wire logic boot_select_strap_bit0_i,
    input wire logic boot_select_strap_bit1_i,
    input wire logic [7:0] boot_override_group_a_i,
    input wire logic [7:0] boot_override_group_b_i,
    input wire logic [7:0] boot_override_group_c_i,
    input wire logic low_battery_indicator_i,
    input wire logic audio_tx_frame_sync_pin_i,
    input wire logic audio_tx_bit_clock_pin_i,
    // shared pin enables from the owning functions and to the pads
    input wire logic [23:0] emi_oe_i,
    output logic [23:0] emi_pin_oe_o,
    input wire logic [1:0] audio_oe_i,
    output logic [1:0] audio_pin_oe_o,
    // captured results
    output logic [1:0] boot_mode_o,
    output logic [23:0] boot_override_o,
    output logic lowbatt_boot_o,
    output logic [1:0] core_freq_sel_o,
    output logic capture_done_o,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [30:0] sync_lv;
    logic por_s;
    logic slow_s;
    logic [1:0] sel_s;
    logic [23:0] ovr_s;
    logic lb_s;
    logic [1:0] freq_s;

    pin_sync #(
        .WIDTH(31)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({por_n_i, slow_reference_clock_i,
                boot_select_strap_bit1_i, boot_select_strap_bit0_i,
                boot_override_group_c_i, boot_override_group_b_i, boot_override_group_a_i,
                low_battery_indicator_i, audio_tx_bit_clock_pin_i, audio_tx_frame_sync_pin_i}),
        .level_o(sync_lv)
    );

    // unpack the synchronised levels
    assign por_s = sync_lv[30];
    assign slow_s = sync_lv[29];
    assign sel_s = sync_lv[28:27];
    assign ovr_s = sync_lv[26:3];
    assign lb_s = sync_lv[2];
    assign freq_s = sync_lv[1:0];

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // strap code to boot mode, used for the port and the status word
    function automatic boot_mode_t decode_boot(input logic [1:0] code);
        unique case (code)
            2'h0: decode_boot = BOOT_INTERNAL;
            2'h2: decode_boot = BOOT_FUSE_ONLY;
            2'h3: decode_boot = BOOT_USB_DL;
            default: decode_boot = BOOT_RESERVED;
        endcase
    endfunction

    cap_regs_t st_r;
    cap_regs_t st_nxt;
    logic slow_rise;
    logic req;
    logic [31:0] status_word;

    assign slow_rise = slow_s & ~st_r.slow_prev;
    assign req = cyc_i & stb_i & ~st_r.ack;

    // status word built from captured state
    always_comb begin
        status_word = 32'h0;
        status_word[`BSC_ST_SEL_LSB +: 2] = decode_boot(st_r.boot_sel);
        status_word[`BSC_ST_LOWBATT] = st_r.lowbatt;
        status_word[`BSC_ST_FREQ_LSB +: 2] = st_r.freq;
        status_word[`BSC_ST_DONE] = st_r.done;
    end

    ////////////////////////////////////////////////////////////////////////
    // capture sequence and register bus

    always_comb begin
        st_nxt = st_r;
        st_nxt.slow_prev = slow_s;
        unique case (st_r.state)
            ST_RESET: begin
                st_nxt.edge_cnt = 3'h0;
                if (por_s) begin
                    st_nxt.boot_sel = sel_s;
                    st_nxt.lowbatt = lb_s;
                    // frequency strap only counts on a low-battery power-up
                    st_nxt.freq = lb_s ? freq_s : `BSC_FREQ_RESET;
                    st_nxt.state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!por_s) begin
                    st_nxt.state = ST_RESET;
                end else if (slow_rise) begin
                    st_nxt.edge_cnt = st_r.edge_cnt + 3'h1;
                    if (st_r.edge_cnt == `BSC_SLOW_EDGES - 3'h1) begin
                        st_nxt.override = ovr_s;
                        st_nxt.done = 1'b1;
                        st_nxt.state = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // values frozen; only a new power-on reset reopens capture
                if (!por_s) begin
                    st_nxt.done = 1'b0;
                    st_nxt.boot_sel = `BSC_SEL_RESET;
                    st_nxt.override = `BSC_OVR_RESET;
                    st_nxt.lowbatt = 1'b0;
                    st_nxt.freq = `BSC_FREQ_RESET;
                    st_nxt.state = ST_RESET;
                end
            end
            // a corrupted one-hot code falls back to waiting for power-on release
            default: begin
                st_nxt.state = ST_RESET;
            end
        endcase
        // one-cycle ack; unmapped reads give zero and writes are dropped
        st_nxt.ack = req;
        if (req) begin
            st_nxt.rdata = 32'h0;
            unique case (adr_i)
                `BSC_ADDR_STATUS: st_nxt.rdata = status_word;
                `BSC_ADDR_OVERRIDE: st_nxt.rdata = {8'h00, st_r.override};
                `BSC_ADDR_CTRL: st_nxt.rdata[`BSC_CTRL_HANDOVER] = st_r.handover;
                default: st_nxt.rdata = 32'h0;
            endcase
            if (we_i && sel_i[0] && adr_i == `BSC_ADDR_CTRL) begin
                st_nxt.handover = dat_i[`BSC_CTRL_HANDOVER];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.state <= ST_RESET;
            st_r.handover <= `BSC_CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // pads stay released until capture so straps are not overdriven
    assign emi_pin_oe_o = (st_r.done && st_r.handover) ? emi_oe_i : 24'h000000;
    assign audio_pin_oe_o = (st_r.done && st_r.handover) ? audio_oe_i : 2'h0;
    assign boot_mode_o = decode_boot(st_r.boot_sel);
    assign boot_override_o = st_r.override;
    assign lowbatt_boot_o = st_r.lowbatt;
    assign core_freq_sel_o = st_r.freq;
    assign capture_done_o = st_r.done;
    assign dat_o = st_r.rdata;
    assign ack_o = st_r.ack;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic por_rel;
    assign por_rel = (st_r.state == ST_RESET) && por_s;

    sel_capture_a: assert property (por_rel |=> st_r.boot_sel == $past(sel_s))
        else $error("boot select not captured at reset release");
    mode_decode_a: assert property ((st_r.boot_sel == 2'h3 |-> boot_mode_o == BOOT_USB_DL)
        and (st_r.boot_sel == 2'h2 |-> boot_mode_o == BOOT_FUSE_ONLY)
        and (st_r.boot_sel == 2'h0 |-> boot_mode_o == BOOT_INTERNAL))
        else $error("boot mode decode wrong");
    override_time_a: assert property ((st_r.state == ST_COUNT && por_s && slow_rise && st_r.edge_cnt == 3'h3)
        |=> capture_done_o && boot_override_o == $past(ovr_s))
        else $error("override not captured on fourth slow edge");
    early_done_a: assert property (st_r.state == ST_COUNT |-> !capture_done_o
        && st_r.edge_cnt < 3'h4)
        else $error("capture done before four slow edges");
    group_order_a: assert property ($rose(capture_done_o) |-> boot_override_o[7:0] == $past(ovr_s[7:0])
        && boot_override_o[23:16] == $past(ovr_s[23:16]))
        else $error("override group order wrong");
    freq_capture_a: assert property (por_rel |=> core_freq_sel_o == ($past(lb_s) ? $past(freq_s) : 2'h0))
        else $error("frequency strap capture wrong");
    freq_pins_a: assert property (por_rel && lb_s && freq_s == 2'h1 |=> core_freq_sel_o[0]
        && !core_freq_sel_o[1])
        else $error("frequency strap bit mapping wrong");
    pin_release_a: assert property (!capture_done_o |-> emi_pin_oe_o == 24'h000000
        && audio_pin_oe_o == 2'h0)
        else $error("shared pins driven before capture");
    hold_value_a: assert property (capture_done_o && por_s |=> $stable(boot_override_o)
        && $stable(boot_mode_o) && $stable(core_freq_sel_o))
        else $error("captured values changed without power-on reset");

    cap_full_c: cover property ($rose(capture_done_o));
    cap_lowbatt_c: cover property (por_rel && lb_s ##1 lowbatt_boot_o);
    cap_repor_c: cover property (capture_done_o ##1 !por_s [*3] ##1 por_s);
    bus_write_c: cover property (req && we_i && adr_i == `BSC_ADDR_CTRL ##1 ack_o);

endmodule

// File: verification/board_straps.sv
/*
 * board_straps: strap resistors and shared-pin traffic at the pads.
 * Assumes the bench hands over the wanted strap pattern for each power-up.
 */
`timescale 1ns/1ps
module board_straps (
    // clock and power-on state
    input wire logic clk_i,
    input wire logic por_n_i,
    input wire logic done_i,
    // wanted {sel1, sel0, lowbatt, freq1, freq0, override}
    input wire logic [28:0] strap_i,
    // pad levels and slow reference
    output logic [28:0] pins_o,
    output logic slow_o
);
    ////////////////////////////////////////////////////////////////
    // crystal runs free, so edges fall at any phase of clk_i
    initial begin
        slow_o = 1'b0;
        forever #15259 slow_o = ~slow_o;
    end

    // resistors hold until capture; then all pads but the two boot selects carry traffic
    always @(posedge clk_i) begin
        if (por_n_i && done_i) begin
            pins_o <= {strap_i[28:27], ~pins_o[26:0]};
        end else begin
            pins_o <= strap_i;
        end
    end
endmodule

// File: verification/tb_top.sv
/*
 * tb_top: power-up cycles with every boot code, then register access.
 * Assumes board_straps stands in for the board and a 100 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
    import boot_strap_pkg::*;
    logic clk_i = 0, rst_i = 1, por_n_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0, dat_o;
    logic [23:0] emi_oe_i = '0, emi_pin_oe_o, boot_override_o;
    logic [1:0] audio_oe_i = '0, audio_pin_oe_o, boot_mode_o, core_freq_sel_o;
    logic ack_o, lowbatt_boot_o, capture_done_o, slow, done_q = 0;
    logic [28:0] strap = '0, pins;
    logic [32:0] exp_rd[$];
    logic [28:0] exp_cap[$];
    int errors = 0, n_compared = 0, n_slow = 0;

    board_straps i_board (.clk_i(clk_i), .por_n_i(por_n_i), .done_i(capture_done_o),
        .strap_i(strap), .pins_o(pins), .slow_o(slow));

    boot_strap_capture i_dut (.clk_i(clk_i), .rst_i(rst_i), .por_n_i(por_n_i),
        .slow_reference_clock_i(slow), .boot_select_strap_bit0_i(pins[27]),
        .boot_select_strap_bit1_i(pins[28]), .boot_override_group_a_i(pins[7:0]),
        .boot_override_group_b_i(pins[15:8]), .boot_override_group_c_i(pins[23:16]),
        .low_battery_indicator_i(pins[26]), .audio_tx_frame_sync_pin_i(pins[24]),
        .audio_tx_bit_clock_pin_i(pins[25]), .emi_oe_i(emi_oe_i),
        .emi_pin_oe_o(emi_pin_oe_o), .audio_oe_i(audio_oe_i),
        .audio_pin_oe_o(audio_pin_oe_o), .boot_mode_o(boot_mode_o),
        .boot_override_o(boot_override_o), .lowbatt_boot_o(lowbatt_boot_o),
        .core_freq_sel_o(core_freq_sel_o), .capture_done_o(capture_done_o),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

    ////////////////////////////////////////////////////////////////
    // clock, watchdog, slow edge count since power-on release
    always #5 clk_i = ~clk_i;
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
    always @(posedge slow) if (por_n_i && !capture_done_o) n_slow++;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        // a note never matched by a result is a missing answer
        if (exp_rd.size() != 0 || exp_cap.size() != 0) errors++;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // monitor: pops the oldest note when a result shows up
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && exp_rd.size() > 0) begin
            if (exp_rd[0][32]) check("read data", dat_o, exp_rd[0][31:0]);
            void'(exp_rd.pop_front());
        end
        if (capture_done_o === 1'b1 && !done_q && exp_cap.size() > 0) begin
            check("captured", {boot_mode_o, lowbatt_boot_o, core_freq_sel_o, boot_override_o},
                exp_cap.pop_front());
            check("slow edges", n_slow, 4);
        end
        done_q <= capture_done_o;
    end

    // one classic cycle; held until ack is sampled
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [32:0] e);
        exp_rd.push_back(e);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
        @(posedge clk_i);
    endtask

    // one power-up with code c, low battery l, frequency f, override o
    task automatic power_up(logic [1:0] c, logic l, logic [1:0] f, logic [23:0] o);
        @(posedge clk_i) por_n_i <= 0;
        repeat (6) @(posedge clk_i);
        check("done cleared", capture_done_o, 0);
        check("pads held", emi_pin_oe_o, 0);
        strap <= {c, l, f[1], f[0], o};
        exp_cap.push_back({c, l, l ? f : 2'h0, o});
        @(posedge slow);
        repeat (100) @(posedge clk_i);
        n_slow = 0;
        por_n_i <= 1;
        repeat (20000) @(posedge clk_i) if (capture_done_o === 1'b1) break;
        check("done", capture_done_o, 1);
        repeat (50) @(posedge clk_i);
        wb(0, 8'h00, '0, 4'hf, {1'b1, 23'h0, 1'b1, 3'h0, l ? f : 2'h0, l, c});
        wb(0, 8'h04, '0, 4'hf, {9'h100, o});
        check("pad oe", emi_pin_oe_o, emi_oe_i);
        $display("power-up with code %0d done", c);
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32195));
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 4; i++) begin
            // enables never all zero, so the gating checks can trip
            emi_oe_i <= 24'($urandom) | 24'h000001;
            audio_oe_i <= 2'($urandom) | 2'h1;
            // code 01 power-up pins frequency 01 to exercise the bit mapping
            power_up(i[1:0], i[0], i[1] ? 2'($urandom) : 2'h1, 24'($urandom));
        end
        wb(0, 8'h0c, '0, 4'hf, {1'b1, 32'h0});
        wb(1, 8'h08, 32'h0, 4'h1, '0);
        check("pads released", emi_pin_oe_o, 0);
        check("audio released", audio_pin_oe_o, 0);
        wb(1, 8'h08, 32'h1, 4'h0, '0);
        wb(0, 8'h08, '0, 4'hf, {1'b1, 32'h0});
        wb(1, 8'h08, 32'h1, 4'h1, '0);
        wb(0, 8'h08, '0, 4'hf, {1'b1, 32'h1});
        check("audio oe", audio_pin_oe_o, audio_oe_i);
        $display("register access done");
        end_of_test();
    end
endmodule
